/* core/motor_fault_supervisor.sv */
// Fault supervision of the motor power stage with AXI4-Lite registers
`default_nettype none
// Operation
// - Over-temperature turns all transistors and pump off, fault pin low, three flags set.
// - Drive and fault pin come back once temperature is below the hysteresis point.
// - Thermal shutdown flag stays until clear command; the protection cannot be disabled.
// - Low-power select 1 chooses sleep, turning power stage and charge pump off and raising the sleep request.
// - Low two select bits pick stage: all off, recirculate, high-side on, low-side on.
// - Lock in latched or retry groups pulls pin low and sets three flags.
// - Latched lock resumes only after condition gone and clear command written.
// - Retry lock resumes after the retry time and clears its flags.
// - Report-only lock keeps driving and sets the flags.
// - Report-only drives the pin low unless the alarm output mask is one.
// - Report-only flags clear after condition gone and clear command written.
// - Disabled pattern 1xx1 ignores lock events entirely.
// - Each lock detector has an enable; cleared enable raises no event.
// - Speed above the overspeed threshold raises an overspeed lock.
// - Back-EMF differing from expected by more than threshold raises a lock.
// - Any phase current below threshold for 500 ms raises a missing-load lock.
// - Ramp-up timer overflowing at all four steps in resistance measurement raises the measurement rl fault.
// - Measured back-EMF below standstill threshold raises the measurement emf fault.
// - Pulse position detection times each ramp with 12-bit timers.
// - Ramp-up retried at four clock steps; all overflowing raises rise timeout.
// - Current decay checked at the same four steps; all overflowing raises fall timeout.
// - Timeout faults need their enable; pulse-rate fault needs its own enable.
// - After a latched fault clears, the clear command returns to operation.
module motor_fault_supervisor
	import fault_sup_pkg::*;
#(
	parameter int MISSING_LOAD_CYCLES = fault_sup_pkg::MISSING_LOAD_CYC,
	parameter int RETRY_UNIT_CYCLES = fault_sup_pkg::RETRY_UNIT_CYC,
	parameter int TIMER_BITS = fault_sup_pkg::PULSE_TIMER_BITS
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// AXI4-Lite slave
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Sensed conditions
	input wire logic over_temp,
	input wire logic temp_below_hyst,
	input wire logic [15:0] motor_speed,
	input wire logic [15:0] emf_estimate,
	input wire logic [15:0] emf_expected,
	input wire logic [2:0] phase_current_low,
	// Measurement and position detection status
	input wire logic meas_rl_active,
	input wire logic meas_emf_active,
	input wire logic [15:0] meas_emf_value,
	input wire logic pulse_start,
	input wire logic pulse_current_reached,
	input wire logic pulse_current_zero,
	// Power stage and supplies
	output logic fault_indicator_pin_o,
	output logic fault_indicator_pin_oe,
	output logic stage_enable,
	output logic [1:0] stage_mode,
	output logic charge_pump_en,
	output logic sleep_req
);
	import fault_sup_pkg::*;

	typedef enum logic [2:0]
	{
		LK_RUN = 3'b001,
		LK_HOLD = 3'b010,
		LK_WAIT = 3'b100
	} lock_state_t;

	typedef enum logic [2:0]
	{
		PD_IDLE = 3'b001,
		PD_RISE = 3'b010,
		PD_FALL = 3'b100
	} pulse_state_t;

	if (TIMER_BITS < 2 || RETRY_UNIT_CYCLES < 1 || MISSING_LOAD_CYCLES < 1)
	begin : bad_param
		$error("motor_fault_supervisor: bad parameter");
	end

	// ----------------------------------------------------------------
	// Register bus
	// ----------------------------------------------------------------
	logic [31:0] ctrl_reg;
	logic [31:0] thresh_reg;
	logic [31:0] meas_reg;
	logic [31:0] status_reg;
	logic clear_pulse_reg;
	logic aw_full_reg;
	logic w_full_reg;
	logic [7:0] aw_addr_reg;
	logic [31:0] w_data_reg;
	logic [3:0] w_strb_reg;
	logic do_write;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
			if (be[i])
				r[i*8 +: 8] = nw[i*8 +: 8];
		return r;
	endfunction : merge

	assign do_write = aw_full_reg && w_full_reg && !s_axi_bvalid;

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			aw_full_reg <= 1'b0;
			w_full_reg <= 1'b0;
			aw_addr_reg <= 8'h00;
			w_data_reg <= 32'h0000_0000;
			w_strb_reg <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end
		else
		begin
			s_axi_awready <= !aw_full_reg && !(s_axi_awvalid && s_axi_awready);
			s_axi_wready <= !w_full_reg && !(s_axi_wvalid && s_axi_wready);
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_full_reg <= 1'b1;
				aw_addr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_full_reg <= 1'b1;
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end
			if (do_write)
			begin
				aw_full_reg <= 1'b0;
				w_full_reg <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (aw_addr_reg == CTRL_OFS || aw_addr_reg == THRESH_OFS ||
					aw_addr_reg == MEAS_OFS || aw_addr_reg == STATUS_OFS) ?
					RESP_OKAY : RESP_SLVERR;
			end
			else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// Control, thresholds; clear command self-clears
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			ctrl_reg <= CTRL_RESET;
			thresh_reg <= 32'h0000_0000;
			meas_reg <= 32'h0000_0000;
			clear_pulse_reg <= 1'b0;
		end
		else
		begin
			clear_pulse_reg <= 1'b0;
			if (do_write && aw_addr_reg == CTRL_OFS)
			begin
				ctrl_reg <= merge(ctrl_reg, w_data_reg, w_strb_reg) & 32'h7fff_ffff;
				clear_pulse_reg <= w_strb_reg[3] && w_data_reg[CLEAR_BIT];
			end
			if (do_write && aw_addr_reg == THRESH_OFS)
				thresh_reg <= merge(thresh_reg, w_data_reg, w_strb_reg);
			if (do_write && aw_addr_reg == MEAS_OFS)
				meas_reg <= merge(meas_reg, w_data_reg, w_strb_reg);
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= RESP_OKAY;
		end
		else
		begin
			s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
			if (s_axi_arvalid && s_axi_arready)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= RESP_OKAY;
				unique case (s_axi_araddr)
					CTRL_OFS: s_axi_rdata <= ctrl_reg;
					THRESH_OFS: s_axi_rdata <= thresh_reg;
					STATUS_OFS: s_axi_rdata <= status_reg;
					MEAS_OFS: s_axi_rdata <= meas_reg;
					default:
					begin
						s_axi_rdata <= 32'h0000_0000;
						s_axi_rresp <= RESP_SLVERR;
					end
				endcase
			end
			else if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Lock detectors
	// ----------------------------------------------------------------
	logic [3:0] lock_sel;
	logic [1:0] startup_sel;
	logic [7:0] retry_units;
	logic [15:0] emf_diff;
	logic [2:0] lock_cond;
	logic [31:0] open_cnt_reg;

	assign lock_sel = ctrl_reg[LOCK_SEL_LSB +: 4];
	assign startup_sel = ctrl_reg[STARTUP_LSB +: 2];
	assign retry_units = ctrl_reg[RETRY_LSB +: 8];
	assign emf_diff = (emf_estimate > emf_expected) ? emf_estimate - emf_expected :
		emf_expected - emf_estimate;

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			open_cnt_reg <= 32'h0000_0000;
		else if (!(|phase_current_low) || !ctrl_reg[OPEN_EN_BIT])
			open_cnt_reg <= 32'h0000_0000;
		else if (open_cnt_reg < 32'(MISSING_LOAD_CYCLES))
			open_cnt_reg <= open_cnt_reg + 32'h0000_0001;
	end

	assign lock_cond[0] = ctrl_reg[SPEED_EN_BIT] && motor_speed > thresh_reg[15:0];
	assign lock_cond[1] = ctrl_reg[EMF_EN_BIT] && emf_diff > thresh_reg[31:16];
	assign lock_cond[2] = ctrl_reg[OPEN_EN_BIT] &&
		open_cnt_reg >= 32'(MISSING_LOAD_CYCLES);

	// ----------------------------------------------------------------
	// Lock response
	// ----------------------------------------------------------------
	lock_state_t lk_reg;
	logic [31:0] retry_cnt_reg;
	logic lock_disabled;
	logic lock_flag_clear;

	assign lock_disabled = lock_sel[3] && lock_sel[0];
	assign lock_flag_clear = (lk_reg == LK_WAIT && retry_cnt_reg == 32'h0000_0000) ||
		(clear_pulse_reg && !(|lock_cond));

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			lk_reg <= LK_RUN;
			retry_cnt_reg <= 32'h0000_0000;
		end
		else
		begin
			unique case (lk_reg)
				LK_RUN:
					if (|lock_cond && !lock_sel[3])
					begin
						if (lock_sel[3:2] == GRP_LATCH)
							lk_reg <= LK_HOLD;
						else
						begin
							lk_reg <= LK_WAIT;
							retry_cnt_reg <= 32'(RETRY_UNIT_CYCLES) * {24'h000000, retry_units};
						end
					end
				LK_HOLD:
					if (clear_pulse_reg && !(|lock_cond))
						lk_reg <= LK_RUN;
				LK_WAIT:
					if (retry_cnt_reg == 32'h0000_0000)
						lk_reg <= LK_RUN;
					else
						retry_cnt_reg <= retry_cnt_reg - 32'h0000_0001;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Measurement and pulse timing
	// ----------------------------------------------------------------
	pulse_state_t pd_reg;
	logic [TIMER_BITS-1:0] tmr_reg;
	logic [11:0] pre_reg;
	logic [1:0] step_reg;
	logic tick;
	logic rise_to;
	logic fall_to;
	logic rate_ev;

	function automatic logic [11:0] step_div(input logic [1:0] s);
		// 25 MHz down to 12.5 MHz, 1 MHz, 100 kHz, 10 kHz
		unique case (s)
			2'd0: return 12'd1;
			2'd1: return 12'd24;
			2'd2: return 12'd249;
			default: return 12'd2499;
		endcase
	endfunction : step_div

	assign tick = pre_reg == 12'h000;
	assign rise_to = pd_reg == PD_RISE && tick && &tmr_reg && step_reg == 2'd3;
	assign fall_to = pd_reg == PD_FALL && tick && &tmr_reg && step_reg == 2'd3;
	assign rate_ev = pulse_start && pd_reg == PD_FALL;

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			pd_reg <= PD_IDLE;
			tmr_reg <= '0;
			pre_reg <= 12'h000;
			step_reg <= 2'd0;
		end
		else
		begin
			pre_reg <= tick ? step_div(step_reg) : pre_reg - 12'h001;
			unique case (pd_reg)
				PD_IDLE:
					if (pulse_start && (startup_sel == STARTUP_PULSE || meas_rl_active))
					begin
						pd_reg <= PD_RISE;
						tmr_reg <= '0;
						step_reg <= 2'd0;
						pre_reg <= step_div(2'd0);
					end
				PD_RISE:
					if (pulse_current_reached)
					begin
						pd_reg <= PD_FALL;
						tmr_reg <= '0;
						step_reg <= 2'd0;
						pre_reg <= step_div(2'd0);
					end
					else if (tick)
					begin
						tmr_reg <= tmr_reg + 1'b1;
						if (&tmr_reg)
						begin
							step_reg <= step_reg + 2'd1;
							if (step_reg == 2'd3)
								pd_reg <= PD_IDLE;
						end
					end
				PD_FALL:
					if (pulse_current_zero)
						pd_reg <= PD_IDLE;
					else if (tick)
					begin
						tmr_reg <= tmr_reg + 1'b1;
						if (&tmr_reg)
						begin
							step_reg <= step_reg + 2'd1;
							if (step_reg == 2'd3)
								pd_reg <= PD_IDLE;
						end
					end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Status flags; a set wins over a clear in the same cycle
	// ----------------------------------------------------------------
	logic lock_event;
	logic [13:0] set_v;
	logic [13:0] clr_v;

	assign lock_event = |lock_cond && !lock_disabled && lk_reg == LK_RUN;

	always_comb
	begin
		set_v = '0;
		clr_v = '0;
		set_v[ST_DRV] = over_temp;
		set_v[ST_OT] = over_temp;
		set_v[ST_TSD] = over_temp;
		set_v[ST_CTL] = lock_event;
		set_v[ST_LOCK] = lock_event;
		set_v[ST_SPD] = lock_event && lock_cond[0];
		set_v[ST_EMF] = lock_event && lock_cond[1];
		set_v[ST_OPEN] = lock_event && lock_cond[2];
		set_v[ST_RL] = meas_rl_active && rise_to;
		set_v[ST_MEMF] = meas_emf_active && meas_emf_value < meas_reg[15:0];
		set_v[ST_RISE] = ctrl_reg[TOUT_EN_BIT] && startup_sel == STARTUP_PULSE && rise_to;
		set_v[ST_FALL] = ctrl_reg[TOUT_EN_BIT] && startup_sel == STARTUP_PULSE && fall_to;
		set_v[ST_RATE] = ctrl_reg[RATE_EN_BIT] && rate_ev;
		clr_v[ST_DRV] = temp_below_hyst;
		clr_v[ST_OT] = temp_below_hyst;
		clr_v[ST_TSD] = clear_pulse_reg && !over_temp;
		clr_v[ST_LOCK:ST_CTL] = {2{lock_flag_clear}};
		clr_v[ST_OPEN:ST_SPD] = {3{lock_flag_clear}};
		clr_v[ST_RATE:ST_RL] = {5{clear_pulse_reg}};
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			status_reg <= 32'h0000_0000;
		else
		begin
			status_reg[12:0] <= set_v[12:0] | (status_reg[12:0] & ~clr_v[12:0]);
			status_reg[ST_SLEEP] <= ctrl_reg[SLEEP_SEL_BIT];
		end
	end

	// ----------------------------------------------------------------
	// Power stage and fault pin
	// ----------------------------------------------------------------
	logic thermal_off;
	logic lock_off;
	logic pin_low;

	assign thermal_off = over_temp || status_reg[ST_DRV];
	assign lock_off = lk_reg != LK_RUN || (lock_event && !lock_sel[3]);
	assign pin_low = thermal_off || lock_off ||
		(lock_sel == LOCK_REPORT && status_reg[ST_LOCK] && !ctrl_reg[MASK_BIT]);

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			fault_indicator_pin_o <= 1'b0;
			fault_indicator_pin_oe <= 1'b0;
			stage_enable <= 1'b0;
			stage_mode <= STAGE_OFF;
			charge_pump_en <= 1'b0;
			sleep_req <= 1'b0;
		end
		else
		begin
			fault_indicator_pin_o <= 1'b0;
			fault_indicator_pin_oe <= pin_low;
			charge_pump_en <= !thermal_off && !ctrl_reg[SLEEP_SEL_BIT];
			sleep_req <= ctrl_reg[SLEEP_SEL_BIT];
			if (thermal_off || ctrl_reg[SLEEP_SEL_BIT])
			begin
				stage_enable <= 1'b0;
				stage_mode <= STAGE_OFF;
			end
			else if (lock_off)
			begin
				stage_enable <= lock_sel[1:0] != STAGE_OFF;
				stage_mode <= lock_sel[1:0];
			end
			else
			begin
				stage_enable <= 1'b1;
				stage_mode <= STAGE_OFF;
			end
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	tsd_pin_low_a: assert property (@(posedge clk) disable iff (!rst_n)
		over_temp |=> fault_indicator_pin_oe && !stage_enable && !charge_pump_en)
		else $error("thermal shutdown not applied");
	tsd_sticky_a: assert property (@(posedge clk) disable iff (!rst_n)
		status_reg[ST_TSD] && !clear_pulse_reg |=> status_reg[ST_TSD])
		else $error("thermal flag dropped");
	lock_ignore_a: assert property (@(posedge clk) disable iff (!rst_n)
		lock_disabled && lk_reg == LK_RUN |=> !status_reg[ST_LOCK] || $past(status_reg[ST_LOCK]))
		else $error("disabled lock acted");
	latch_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
		lk_reg == LK_HOLD && !clear_pulse_reg |=> lk_reg == LK_HOLD)
		else $error("latched lock released early");
	speed_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
		!ctrl_reg[SPEED_EN_BIT] |-> !lock_cond[0])
		else $error("disabled detector fired");
	lock_set_a: assert property (@(posedge clk) disable iff (!rst_n)
		lock_event |=> status_reg[ST_LOCK] && status_reg[ST_CTL])
		else $error("lock flags not set");
	report_pin_a: assert property (@(posedge clk) disable iff (!rst_n)
		lock_sel == LOCK_REPORT && ctrl_reg[MASK_BIT] && !thermal_off && lk_reg == LK_RUN
		|=> !fault_indicator_pin_oe)
		else $error("masked pin driven");
	rate_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
		!ctrl_reg[RATE_EN_BIT] && !status_reg[ST_RATE] |=> !status_reg[ST_RATE])
		else $error("rate fault without enable");
endmodule : motor_fault_supervisor
`default_nettype wire

/* inc/fault_sup_pkg.sv */
// Constants for the motor fault supervisor
`default_nettype none
package fault_sup_pkg;
	// Register byte offsets
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] THRESH_OFS = 8'h04;
	localparam logic [7:0] STATUS_OFS = 8'h08;
	localparam logic [7:0] MEAS_OFS = 8'h0c;
	// Control register field positions
	localparam int LOCK_SEL_LSB = 0;
	localparam int SPEED_EN_BIT = 4;
	localparam int EMF_EN_BIT = 5;
	localparam int OPEN_EN_BIT = 6;
	localparam int MASK_BIT = 7;
	localparam int TOUT_EN_BIT = 8;
	localparam int RATE_EN_BIT = 9;
	localparam int SLEEP_SEL_BIT = 10;
	localparam int STARTUP_LSB = 11;
	localparam int RETRY_LSB = 16;
	localparam int CLEAR_BIT = 31;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0070;
	// Status register bit positions
	localparam int ST_DRV = 0;
	localparam int ST_OT = 1;
	localparam int ST_TSD = 2;
	localparam int ST_CTL = 3;
	localparam int ST_LOCK = 4;
	localparam int ST_SPD = 5;
	localparam int ST_EMF = 6;
	localparam int ST_OPEN = 7;
	localparam int ST_RL = 8;
	localparam int ST_MEMF = 9;
	localparam int ST_RISE = 10;
	localparam int ST_FALL = 11;
	localparam int ST_RATE = 12;
	localparam int ST_SLEEP = 13;
	// Lock response encodings
	localparam logic [1:0] GRP_LATCH = 2'b00;
	localparam logic [1:0] GRP_RETRY = 2'b01;
	localparam logic [3:0] LOCK_REPORT = 4'b1000;
	localparam logic [1:0] STAGE_OFF = 2'b00;
	localparam logic [1:0] STAGE_RECIRC = 2'b01;
	localparam logic [1:0] STAGE_HIGH = 2'b10;
	localparam logic [1:0] STAGE_LOW = 2'b11;
	localparam logic [1:0] STARTUP_PULSE = 2'b10;
	// Timing
	localparam int CLK_HZ = 25_000_000;
	localparam int MISSING_LOAD_MS = 500;
	localparam int MISSING_LOAD_CYC = MISSING_LOAD_MS * (CLK_HZ / 1000);
	localparam int RETRY_UNIT_MS = 100;
	localparam int RETRY_UNIT_CYC = RETRY_UNIT_MS * (CLK_HZ / 1000);
	localparam int PULSE_TIMER_BITS = 12;
	localparam int PULSE_STEPS = 4;
	// AXI response codes
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage : fault_sup_pkg
`default_nettype wire

/* verif/ext_ctrl_model.sv */
// Far-side controller model: resolves the open-drain fault line
`default_nettype none
module ext_ctrl_model
(
	// Fault line from the supervisor
	input wire logic pin_o,
	input wire logic pin_oe,
	// Line level seen by the controller
	output logic fault_n
);
	timeunit 1ns;
	timeprecision 1ns;
	// Pull-up holds the line high when undriven
	assign fault_n = pin_oe ? pin_o : 1'b1;
endmodule : ext_ctrl_model
`default_nettype wire

/* verif/tb_top.sv */
// Self-checking bench for the motor fault supervisor
`default_nettype none
module tb_top
	import fault_sup_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	// ----
	// Signals
	// ----
	logic clk = 0, rst_n = 0;
	logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, d, ctrl;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [31:0] s_axi_rdata;
	logic [1:0] s_axi_rresp, s_axi_bresp, stage_mode, r, b;
	logic over_temp = 0, temp_below_hyst = 1, meas_emf_active = 0;
	logic meas_rl_active = 0, pulse_start = 0, pulse_current_reached = 0;
	logic pulse_current_zero = 0;
	logic [15:0] motor_speed = 0, emf_estimate = 0, meas_emf_value = 0, emf_expected = 0;
	logic [2:0] phase_current_low = 0;
	logic fault_indicator_pin_o, fault_indicator_pin_oe, fault_n;
	logic stage_enable, charge_pump_en, sleep_req;
	logic [31:0] quiet [2] = '{32'h79, 32'h60};
	int fails = 0, n_tests = 0;

	motor_fault_supervisor #(.MISSING_LOAD_CYCLES(20), .RETRY_UNIT_CYCLES(10),
		.TIMER_BITS(4)) u_dut (.clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.over_temp, .temp_below_hyst, .motor_speed, .emf_estimate,
		.emf_expected, .phase_current_low, .meas_rl_active,
		.meas_emf_active, .meas_emf_value, .pulse_start,
		.pulse_current_reached, .pulse_current_zero,
		.fault_indicator_pin_o, .fault_indicator_pin_oe, .stage_enable, .stage_mode,
		.charge_pump_en, .sleep_req);
	ext_ctrl_model u_ctrl (.pin_o(fault_indicator_pin_o),
		.pin_oe(fault_indicator_pin_oe), .fault_n);

	initial forever #20 clk = ~clk;
	// ----
	// Tasks
	// ----
	task automatic print_verdict();
		$display("tests %0d fails %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : print_verdict
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e)
		begin
			fails++;
			$display("[FAIL] t=%0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
	endtask : wt
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(posedge clk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end
		while (s_axi_bvalid !== 1'b1);
		b = s_axi_bresp;
		s_axi_bready <= 1'b0;
		@(posedge clk);
	endtask : wr
	task automatic rd(input logic [7:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
			@(posedge clk);
		while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do
			@(posedge clk);
		while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
		@(posedge clk);
	endtask : rd
	task automatic st(input logic [31:0] m, input logic [31:0] e);
		rd(STATUS_OFS);
		chk(d & m, e);
	endtask : st
	task automatic pins(input logic [3:0] m, input logic [3:0] e);
		chk({28'h0, {fault_n, stage_enable, stage_mode} & m}, {28'h0, e & m});
	endtask : pins
	task automatic clr();
		wr(CTRL_OFS, ctrl | 32'h8000_0000);
		wt(2);
	endtask : clr
	// ----
	// Tests
	// ----
	initial
	begin
		wt(95000);
		fails++;
		print_verdict();
	end
	initial
	begin
		wt(8);
		rst_n <= 1'b1;
		wt(1);
		rd(CTRL_OFS);
		chk(d, CTRL_RESET);
		rd(8'h40);
		chk({30'h0, r}, {30'h0, RESP_SLVERR});
		wr(THRESH_OFS, 32'h0010_0100);
		chk({30'h0, b}, {30'h0, RESP_OKAY});
		wr(8'h40, 32'h0000_0000);
		chk({30'h0, b}, {30'h0, RESP_SLVERR});
		wr(MEAS_OFS, 32'h0000_0020);
		ctrl = CTRL_RESET;
		over_temp <= 1'b1;
		temp_below_hyst <= 1'b0;
		wt(4);
		chk({29'h0, fault_n, stage_enable, charge_pump_en}, 32'h0);
		st(32'h6, 32'h6);
		over_temp <= 1'b0;
		temp_below_hyst <= 1'b1;
		wt(4);
		chk({29'h0, fault_n, stage_enable, charge_pump_en}, 32'h7);
		st(32'h6, 32'h4);
		clr();
		st(32'h6, 32'h0);
		for (int i = 0; i < 4; i++)
		begin
			ctrl = 32'h70 | i;
			wr(CTRL_OFS, ctrl);
			motor_speed <= 16'h0200;
			wt(4);
			pins(4'hb, {2'b00, i[1:0]});
			st(32'h38, 32'h38);
			motor_speed <= 16'h0;
			wt(4);
			pins(4'h8, 4'h0);
			clr();
			pins(4'hc, 4'hc);
		end
		ctrl = 32'h0002_0074;
		wr(CTRL_OFS, ctrl);
		motor_speed <= 16'h0200;
		wt(4);
		pins(4'h8, 4'h0);
		motor_speed <= 16'h0;
		wt(30);
		pins(4'hc, 4'hc);
		st(32'h38, 32'h0);
		for (int m = 0; m < 2; m++)
		begin
			ctrl = 32'h78 | (m << 7);
			wr(CTRL_OFS, ctrl);
			motor_speed <= 16'h0200;
			wt(4);
			pins(4'hc, {m[0], 3'b100});
			st(32'h38, 32'h38);
			motor_speed <= 16'h0;
			wt(4);
			st(32'h38, 32'h38);
			clr();
			st(32'h38, 32'h0);
		end
		for (int k = 0; k < 2; k++)
		begin
			ctrl = quiet[k];
			wr(CTRL_OFS, ctrl);
			motor_speed <= 16'h0200;
			wt(4);
			pins(4'hc, 4'hc);
			st(32'h38, 32'h0);
			motor_speed <= 16'h0;
		end
		ctrl = CTRL_RESET;
		wr(CTRL_OFS, ctrl);
		emf_estimate <= 16'h0040;
		emf_expected <= 16'h0038;
		wt(4);
		st(32'h40, 32'h0);
		emf_expected <= 16'h0090;
		wt(4);
		st(32'h58, 32'h58);
		emf_estimate <= 16'h0;
		emf_expected <= 16'h0;
		clr();
		phase_current_low <= 3'b010;
		wt(8);
		st(32'h80, 32'h0);
		wt(16);
		st(32'h98, 32'h98);
		phase_current_low <= 3'b000;
		clr();
		meas_emf_value <= 16'h0010;
		meas_emf_active <= 1'b1;
		wt(4);
		st(32'h200, 32'h200);
		meas_emf_active <= 1'b0;
		ctrl = 32'h0000_1370;
		wr(CTRL_OFS, ctrl);
		meas_rl_active <= 1'b1;
		pulse_start <= 1'b1;
		wt(1);
		pulse_start <= 1'b0;
		wt(100);
		st(32'h500, 32'h0);
		wt(44500);
		st(32'h500, 32'h500);
		meas_rl_active <= 1'b0;
		clr();
		pulse_start <= 1'b1;
		wt(1);
		pulse_start <= 1'b0;
		pulse_current_reached <= 1'b1;
		wt(1);
		pulse_current_reached <= 1'b0;
		pulse_current_zero <= 1'b1;
		wt(1);
		pulse_current_zero <= 1'b0;
		pulse_start <= 1'b1;
		wt(1);
		pulse_start <= 1'b0;
		wt(2);
		st(32'h1800, 32'h0);
		pulse_current_reached <= 1'b1;
		wt(1);
		pulse_current_reached <= 1'b0;
		pulse_start <= 1'b1;
		wt(1);
		pulse_start <= 1'b0;
		wt(2);
		st(32'h1000, 32'h1000);
		wt(44500);
		st(32'h800, 32'h800);
		wr(CTRL_OFS, 32'h0000_0470);
		wt(2);
		chk({31'h0, sleep_req}, 32'h1);
		chk({30'h0, stage_enable, charge_pump_en}, 32'h0);
		st(32'h2000, 32'h2000);
		print_verdict();
	end
endmodule : tb_top
`default_nettype wire
